// ===== common/sas_pkg.sv
package sas_pkg;
   // hold timer state codes
   typedef enum logic [1:0] {
      SAS_HOLD_IDLE,
      SAS_HOLD_RUN,
      SAS_HOLD_EXPIRED
   } sas_hold_t;

   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 5;
   // 1 Hz flash: half period toggles
   localparam int unsigned FLASH_HZ        = 1;
   localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (2 * FLASH_HZ);
   // sync-loss hold time in ms (plain default)
   localparam int unsigned HOLD_MS         = 1000;
   localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1000);
   // supervision pulse half period and return timeout in us
   localparam int unsigned SUP_HALF_US     = 100;
   localparam int unsigned SUP_HALF_CYC    = SUP_HALF_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SUP_TMO_US      = 1000;
   localparam int unsigned SUP_TMO_CYC     = SUP_TMO_US * (CLK_HZ / 1_000_000);
   // system reset pulse length in us
   localparam int unsigned RST_PULSE_US    = 50;
   localparam int unsigned RST_PULSE_CYC   = RST_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FAULT_W         = 8;
   localparam int unsigned POS_DIGITS      = 2;
   localparam logic [3:0]  POS_ZERO        = 4'h0;
endpackage

// ===== common/sas_bus_if.sv
interface sas_bus_if;
   logic sup_out;
   logic sup_ret;
   logic sys_reset;

   modport ctrl  (output sup_out, output sys_reset, input sup_ret);
   modport board (input sup_out, input sys_reset, output sup_ret);
endinterface

// ===== src/sas_timer.sv
module sas_timer #(
   parameter int unsigned W = 32
) (
   // clocking
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic         ce,
   // control
   input  wire logic         restart,
   input  wire logic [W-1:0] limit,
   // status
   output logic              done
);
   logic [W-1:0] cnt_r;

   assign done = (cnt_r == limit);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (restart) begin
            cnt_r <= '0;
         end else if (!done) begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end
endmodule

// ===== src/sas_board.sv
module sas_board #(
   parameter bit HAS_CPU = 1'b1
) (
   // clocking
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic ce,
   // bus side
   sas_bus_if.board  bus,
   // user side
   input  wire logic cpu_ok,
   output logic      restart_req
);
   logic sup_m_r;
   logic sup_s_r;
   logic rst_m_r;
   logic rst_s_r;
   logic fwd_r;
   logic rst_d_r;

   // forward only while healthy; bridge without cpu
   assign bus.sup_ret = HAS_CPU ? fwd_r : sup_s_r;
   assign restart_req = rst_s_r & ~rst_d_r;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sup_m_r <= 1'b0;
         sup_s_r <= 1'b0;
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
         fwd_r   <= 1'b0;
         rst_d_r <= 1'b0;
      end else if (ce) begin
         sup_m_r <= bus.sup_out;
         sup_s_r <= sup_m_r;
         rst_m_r <= bus.sys_reset;
         rst_s_r <= rst_m_r;
         rst_d_r <= rst_s_r;
         fwd_r   <= sup_s_r & cpu_ok & ~rst_s_r;
      end
   end
endmodule

// ===== src/sas_ctrl.sv
// How it works
// - sync LED green when synchronous, else red
// - sync relay energized while synchronous
// - hold timer keeps sync shown after loss
// - hold timer reports running, expired, inactive
// - fault byte set: marker and 1Hz flash
// - manual position shows zeros until synced
// - drive supervision signal, check its return
// - each board forwards signal to next
// - stalled chain causes system-wide reset
// - boards restart on system reset
// - cpu boards forward only when healthy
// - empty slot bridged to keep chain
module sas_ctrl #(
   parameter int unsigned HOLD_CYC  = sas_pkg::HOLD_CYC,
   parameter int unsigned FLASH_CYC = sas_pkg::FLASH_HALF_CYC,
   parameter int unsigned SUP_HALF  = sas_pkg::SUP_HALF_CYC,
   parameter int unsigned SUP_TMO   = sas_pkg::SUP_TMO_CYC,
   parameter int unsigned RST_CYC   = sas_pkg::RST_PULSE_CYC
) (
   // clocking
   input  wire logic                           clock,
   input  wire logic                           rstn,
   input  wire logic                           ce,
   // sync source
   input  wire logic                           sync_in,
   input  wire logic                           hold_en,
   // fault byte
   input  wire logic [sas_pkg::FAULT_W-1:0]    fault_byte,
   // position digits
   input  wire logic                           pos_manual,
   input  wire logic [4*sas_pkg::POS_DIGITS-1:0] pos_rx,
   // bus side
   sas_bus_if.ctrl                             bus,
   // indicators
   output logic                                led_green,
   output logic                                led_red,
   output logic                                sync_relay,
   output sas_pkg::sas_hold_t                  hold_state,
   output logic                                fault_mark,
   output logic                                backlight,
   output logic [4*sas_pkg::POS_DIGITS-1:0]    pos_low,
   output logic                                reset_active
);
   ////////////////////////////////////////////////////////////////////////////
   logic      sync_m_r;
   logic      sync_s_r;
   logic      shown_r;
   logic      ret_m_r;
   logic      ret_s_r;
   logic      ret_d_r;
   logic      sup_r;
   logic      rst_r;
   logic      flash_r;
   logic      fault_r;
   logic      light_r;
   logic [4*sas_pkg::POS_DIGITS-1:0] pos_r;
   sas_pkg::sas_hold_t hold_r;
   sas_pkg::sas_hold_t hold_nxt;

   wire       hold_done;
   wire       flash_done;
   wire       half_done;
   wire       tmo_done;
   wire       rst_done;
   wire       ret_edge;
   wire       fault_any;
   wire       shown_nxt;
   wire       flash_nxt;

   // true while the hold timer counts
   function automatic logic hold_running(input sas_pkg::sas_hold_t s);
      return s == sas_pkg::SAS_HOLD_RUN;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // hold timer state
   always_comb begin
      hold_nxt = hold_r;
      case (hold_r)
         sas_pkg::SAS_HOLD_IDLE:
            if (!sync_s_r && shown_r && hold_en) begin
               hold_nxt = sas_pkg::SAS_HOLD_RUN;
            end
         sas_pkg::SAS_HOLD_RUN:
            if (sync_s_r) begin
               hold_nxt = sas_pkg::SAS_HOLD_IDLE;
            end else if (hold_done) begin
               hold_nxt = sas_pkg::SAS_HOLD_EXPIRED;
            end
         sas_pkg::SAS_HOLD_EXPIRED:
            if (sync_s_r) begin
               hold_nxt = sas_pkg::SAS_HOLD_IDLE;
            end
         default:
            hold_nxt = sas_pkg::SAS_HOLD_IDLE;
      endcase
   end

   assign shown_nxt = sync_s_r
                    | hold_running(hold_nxt);

   sas_timer #(.W(32)) u_hold (
      .clock   (clock),
      .rstn    (rstn),
      .ce      (ce),
      .restart (!hold_running(hold_r)),
      .limit   (HOLD_CYC),
      .done    (hold_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // indicators
   assign led_green  = shown_r;
   assign led_red    = ~shown_r;
   assign sync_relay = shown_r;
   assign hold_state = hold_r;
   assign fault_any  = |fault_byte;
   assign fault_mark = fault_r;
   assign backlight  = light_r;
   assign flash_nxt  = fault_any & (flash_r ^ flash_done);
   assign pos_low    = pos_r;

   sas_timer #(.W(32)) u_flash (
      .clock   (clock),
      .rstn    (rstn),
      .ce      (ce),
      .restart (flash_done | ~fault_any),
      .limit   (FLASH_CYC - 1),
      .done    (flash_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // supervision chain
   assign bus.sup_out   = sup_r;
   assign bus.sys_reset = rst_r;
   assign reset_active  = rst_r;
   assign ret_edge      = ret_s_r ^ ret_d_r;

   sas_timer #(.W(32)) u_half (
      .clock   (clock),
      .rstn    (rstn),
      .ce      (ce),
      .restart (half_done | rst_r),
      .limit   (SUP_HALF - 1),
      .done    (half_done)
   );

   sas_timer #(.W(32)) u_tmo (
      .clock   (clock),
      .rstn    (rstn),
      .ce      (ce),
      .restart (ret_edge | rst_r),
      .limit   (SUP_TMO - 1),
      .done    (tmo_done)
   );

   sas_timer #(.W(32)) u_rst (
      .clock   (clock),
      .rstn    (rstn),
      .ce      (ce),
      .restart (~rst_r),
      .limit   (RST_CYC - 1),
      .done    (rst_done)
   );

   // synchronisers, indicator registers and chain control
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync_m_r <= 1'b0;
         sync_s_r <= 1'b0;
         shown_r  <= 1'b0;
         hold_r   <= sas_pkg::SAS_HOLD_IDLE;
         flash_r  <= 1'b0;
         fault_r  <= 1'b0;
         light_r  <= 1'b1;
         pos_r    <= '0;
         ret_m_r  <= 1'b0;
         ret_s_r  <= 1'b0;
         ret_d_r  <= 1'b0;
         sup_r    <= 1'b0;
         rst_r    <= 1'b0;
      end else if (ce) begin
         sync_m_r <= sync_in;
         sync_s_r <= sync_m_r;
         hold_r   <= hold_nxt;
         shown_r  <= shown_nxt;
         flash_r  <= flash_nxt;
         fault_r  <= fault_any;
         light_r  <= ~fault_any | flash_nxt;
         pos_r    <= (pos_manual && !sync_s_r)
                   ? {sas_pkg::POS_DIGITS{sas_pkg::POS_ZERO}}
                   : pos_rx;
         ret_m_r  <= bus.sup_ret;
         ret_s_r  <= ret_m_r;
         ret_d_r  <= ret_s_r;
         if (rst_r) begin
            sup_r <= 1'b0;
            rst_r <= ~rst_done;
         end else begin
            sup_r <= sup_r ^ half_done;
            rst_r <= tmo_done;
         end
      end
   end
endmodule

// ===== bench/sas_assertions.sv
module sas_assertions #(
   parameter int unsigned SUP_TMO = 40,
   parameter int unsigned RST_CYC = 5
) (
   // clocking
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // bus
   input wire logic sup_out,
   input wire logic sup_ret,
   input wire logic sys_reset,
   // board health
   input wire logic cpu_ok
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn || !ce);
   logic [15:0] quiet_r;
   logic [15:0] hi_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         quiet_r <= 16'h0000;
         hi_r    <= 16'h0000;
      end else if (ce) begin
         quiet_r <= (sys_reset || $changed(sup_ret)) ? 16'h0000
                    : quiet_r + 16'h0001;
         hi_r    <= sys_reset ? hi_r + 16'h0001 : 16'h0000;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_rst_len; $fell(sys_reset) |-> hi_r == RST_CYC; endproperty
   a_rst_len: assert property (p_rst_len) else $error("bad pulse");
   property p_hold0; sys_reset && $past(sys_reset) |-> !sup_out; endproperty
   a_hold0: assert property (p_hold0) else $error("sup_out live");
   property p_tmo; $rose(sys_reset) |-> quiet_r >= SUP_TMO; endproperty
   a_tmo: assert property (p_tmo) else $error("early reset");
   property p_dead; quiet_r < SUP_TMO + 16; endproperty
   a_dead: assert property (p_dead) else $error("no reset");
   property p_gap; $fell(sys_reset) |-> !sys_reset [*8]; endproperty
   a_gap: assert property (p_gap) else $error("reset gap");
   property p_fwd;
      $rose(sup_out) && cpu_ok |-> ##[1:6] (sup_ret || !cpu_ok || sys_reset);
   endproperty
   a_fwd: assert property (p_fwd) else $error("not forwarded");
   property p_stop; !cpu_ok [*4] |-> !sup_ret; endproperty
   a_stop: assert property (p_stop) else $error("forwarded");
   property p_rst_ret; sys_reset [*4] |-> !sup_ret; endproperty
   a_rst_ret: assert property (p_rst_ret) else $error("no restart");
endmodule

// ===== bench/sas_tb.sv
module sas_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned TMO = 40;
   localparam int unsigned RST = 5;
   logic clock, rstn, ce, sync_in, hold_en, pos_manual, cpu_ok, rst_q;
   logic led_green, led_red, sync_relay, fault_mark, backlight;
   logic reset_active, restart_req, b;
   logic [7:0] fault_byte, pos_rx, pos_low;
   sas_pkg::sas_hold_t hold_state;
   int n_mismatch, check_count, n_rst, n_req, n_act, n0;
   sas_bus_if bus_if_inst ();
   sas_ctrl #(.HOLD_CYC(50), .FLASH_CYC(10), .SUP_HALF(8), .SUP_TMO(TMO),
      .RST_CYC(RST)) sas_ctrl_inst (.clock, .rstn, .ce, .sync_in, .hold_en,
      .fault_byte, .pos_manual, .pos_rx, .bus(bus_if_inst), .led_green,
      .led_red, .sync_relay, .hold_state, .fault_mark, .backlight, .pos_low,
      .reset_active);
   sas_board sas_board_inst (.clock, .rstn, .ce, .bus(bus_if_inst), .cpu_ok,
      .restart_req);
   sas_assertions #(.SUP_TMO(TMO), .RST_CYC(RST)) sas_assertions_inst (
      .clock, .rstn, .ce, .sup_out(bus_if_inst.sup_out),
      .sup_ret(bus_if_inst.sup_ret), .sys_reset(bus_if_inst.sys_reset),
      .cpu_ok);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      results();
   end
   always @(posedge clock) begin
      if (bus_if_inst.sys_reset === 1'b1 && rst_q !== 1'b1) n_rst++;
      if (restart_req === 1'b1) n_req++;
      if (reset_active === 1'b1) n_act++;
      rst_q = bus_if_inst.sys_reset;
   end
   initial begin
      {rstn, sync_in, hold_en, rst_q, b} = 5'h00;
      {ce, pos_manual, cpu_ok} = 3'h7;
      fault_byte = 8'h00;
      pos_rx = 8'h47;
      cyc(3);
      chk("led_red", 8'h01, {7'h00, led_red});
      chk("relay", 8'h00, {7'h00, sync_relay});
      chk("hold", 8'h00, {6'h00, hold_state});
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      cyc(4);
      chk("pos_low", 8'h00, pos_low);
      @(posedge clock);
      sync_in <= 1'b1;
      hold_en <= 1'b1;
      cyc(6);
      chk("led_green", 8'h01, {7'h00, led_green});
      chk("relay", 8'h01, {7'h00, sync_relay});
      chk("pos_low", 8'h47, pos_low);
      @(posedge clock);
      sync_in <= 1'b0;
      cyc(10);
      chk("led_green", 8'h01, {7'h00, led_green});
      chk("hold", 8'h01, {6'h00, hold_state});
      @(posedge clock);
      ce <= 1'b0;
      cyc(50);
      chk("hold_frozen", 8'h01, {6'h00, hold_state});
      chk("led_green", 8'h01, {7'h00, led_green});
      @(posedge clock);
      ce <= 1'b1;
      cyc(50);
      chk("led_red", 8'h01, {7'h00, led_red});
      chk("relay", 8'h00, {7'h00, sync_relay});
      chk("hold", 8'h02, {6'h00, hold_state});
      @(posedge clock);
      sync_in <= 1'b1;
      cyc(6);
      chk("hold", 8'h00, {6'h00, hold_state});
      @(posedge clock);
      hold_en <= 1'b0;
      sync_in <= 1'b0;
      cyc(6);
      chk("led_red", 8'h01, {7'h00, led_red});
      chk("pos_low", 8'h00, pos_low);
      @(posedge clock);
      fault_byte <= 8'h10;
      pos_manual <= 1'b0;
      cyc(3);
      chk("fault_mark", 8'h01, {7'h00, fault_mark});
      chk("pos_low", 8'h47, pos_low);
      b = backlight;
      cyc(10);
      chk("backlight", {7'h00, ~b}, {7'h00, backlight});
      @(posedge clock);
      fault_byte <= 8'h00;
      cyc(3);
      chk("backlight", 8'h01, {7'h00, backlight});
      chk("fault_mark", 8'h00, {7'h00, fault_mark});
      cyc(10);
      chk("backlight", 8'h01, {7'h00, backlight});
      cyc(200);
      chk("resets", 8'h00, 8'(n_rst));
      @(posedge clock);
      cpu_ok <= 1'b0;
      cyc(TMO + 20);
      chk("resets", 8'h01, 8'(n_rst));
      chk("restarts", 8'h01, 8'(n_req));
      chk("reset_len", 8'(RST), 8'(n_act));
      cyc(100);
      chk("cyclic", 8'h01, {7'h00, n_rst >= 2});
      @(posedge clock);
      cpu_ok <= 1'b1;
      cyc(100);
      n0 = n_rst;
      cyc(200);
      chk("recovered", 8'(n0), 8'(n_rst));
      results();
   end
endmodule
